// file: core/srr_pkg.sv
// Constants and types for the refresh rate and self-refresh block
package srr_pkg;
    // ========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TRFC1_NS = 350;
    localparam int TRFC2_NS = 260;
    localparam int TRFC4_NS = 160;
    localparam int XS_MARGIN_NS = 10;
    localparam int ABORT_EXIT_NS = TRFC4_NS + XS_MARGIN_NS;
    localparam int TREFI_BASE_NS = 7800;
    localparam int CNT_W = 11;
    // Least times round up, the refresh interval rounds down
    localparam int TRFC1_CYC = (TRFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRFC2_CYC = (TRFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRFC4_CYC = (TRFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XS1_CYC =
        (TRFC1_NS + XS_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XS2_CYC =
        (TRFC2_NS + XS_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XS4_CYC =
        (TRFC4_NS + XS_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_EXIT_CYC = XS4_CYC;
    localparam int ABORT_EXIT_CYC =
        (ABORT_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLL_LOCK_EXIT_CYC = 1024;
    localparam int TREFI_CYC = TREFI_BASE_NS / CLK_PERIOD_NS;

    // ========================================================
    // Register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_REFCNT = 4'h8;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TCR_BIT = 3;
    localparam int CTRL_ABORT_BIT = 4;
    localparam int CTRL_WREF_BIT = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Granularity codes of refresh_granularity_mode
    localparam logic [2:0] MODE_FIX1 = 3'h0;
    localparam logic [2:0] MODE_FIX2 = 3'h1;
    localparam logic [2:0] MODE_FIX4 = 3'h2;
    localparam logic [2:0] MODE_OTF12 = 3'h5;
    localparam logic [2:0] MODE_OTF14 = 3'h6;

    typedef enum logic [1:0] {
        RATE_1X = 2'h0,
        RATE_2X = 2'h1,
        RATE_4X = 2'h2
    } srr_rate_t;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'h0,
        ST_SELF = 2'h1,
        ST_EXIT = 2'h3
    } srr_state_t;
endpackage

// file: core/srr_refresh_ctrl.sv
// Refresh granularity bookkeeping and self-refresh entry/exit logic
`timescale 1ns/1ns

// Summary of operation
// - New rate's timings apply from change
// - Self-refresh entry accepted at any count
// - Entry decoded from command pins, CKE low
// - In self refresh only CKE and CS_n matter
// - Entry kills termination and DLL; exit restores
// - Write reference readiness follows keep-on bit
// - Internal refresh starts at once, then timer
// - Abort bit cuts internal refresh on exit
module srr_refresh_ctrl (
    input wire logic aclk,              // System clock
    input wire logic aresetn,           // Sync reset, active low
    input wire logic [3:0] awaddr,      // Write address
    input wire logic awvalid,           // Write address valid
    output logic awready,               // Write address ready
    input wire logic [31:0] wdata,      // Write data
    input wire logic [3:0] wstrb,       // Write byte enables
    input wire logic wvalid,            // Write data valid
    output logic wready,                // Write data ready
    output logic [1:0] bresp,           // Write response
    output logic bvalid,                // Write response valid
    input wire logic bready,            // Write response ready
    input wire logic [3:0] araddr,      // Read address
    input wire logic arvalid,           // Read address valid
    output logic arready,               // Read address ready
    output logic [31:0] rdata,          // Read data
    output logic [1:0] rresp,           // Read response
    output logic rvalid,                // Read data valid
    input wire logic rready,            // Read data ready
    input wire logic cke,               // Clock enable pin
    input wire logic cs_n,              // Chip select pin
    input wire logic act_n,             // Activate pin
    input wire logic ras_n,             // Row strobe pin
    input wire logic cas_n,             // Column strobe pin
    input wire logic we_n,              // Write enable pin
    input wire logic bg0,               // Bank group 0, OTF rate select
    output logic in_self_refresh,       // Device in self refresh
    output logic odt_enable,            // Termination allowed
    output logic dll_enable,            // DLL running
    output logic dll_reset,             // DLL reset pulse on exit
    output logic write_ref_on,          // Write reference generator on
    output logic ready_no_dll,          // Non-DLL commands allowed
    output logic ready_fast,            // ZQ and limited mode writes ok
    output logic ready_dll,             // DLL commands allowed
    output logic write_ready            // First write allowed
);
    // ========================================================
    // Pin synchronisers
    logic [6:0] pin_in;
    logic [6:0] pin_m_ff;
    logic [6:0] pin_s_ff;
    assign pin_in = {bg0, we_n, cas_n, ras_n, act_n, cs_n, cke};
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            // Two stages per pin
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_m_ff[gi] <= 1'b0;
                    pin_s_ff[gi] <= 1'b0;
                end else begin
                    pin_m_ff[gi] <= pin_in[gi];
                    pin_s_ff[gi] <= pin_m_ff[gi];
                end
            end
        end
    endgenerate

    // ========================================================
    // Helpers
    localparam int CNT_W = srr_pkg::CNT_W;
    function automatic logic [CNT_W-1:0] trfc_of(input srr_pkg::srr_rate_t r);
        case (r)
            srr_pkg::RATE_2X: trfc_of = CNT_W'(srr_pkg::TRFC2_CYC);
            srr_pkg::RATE_4X: trfc_of = CNT_W'(srr_pkg::TRFC4_CYC);
            default: trfc_of = CNT_W'(srr_pkg::TRFC1_CYC);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] xs_of(input srr_pkg::srr_rate_t r);
        case (r)
            srr_pkg::RATE_2X: xs_of = CNT_W'(srr_pkg::XS2_CYC);
            srr_pkg::RATE_4X: xs_of = CNT_W'(srr_pkg::XS4_CYC);
            default: xs_of = CNT_W'(srr_pkg::XS1_CYC);
        endcase
    endfunction

    // Sub rate of a granularity code; 1x where none
    function automatic srr_pkg::srr_rate_t sub_of(input logic [2:0] m);
        case (m)
            srr_pkg::MODE_FIX2, srr_pkg::MODE_OTF12: sub_of = srr_pkg::RATE_2X;
            srr_pkg::MODE_FIX4, srr_pkg::MODE_OTF14: sub_of = srr_pkg::RATE_4X;
            default: sub_of = srr_pkg::RATE_1X;
        endcase
    endfunction

    logic cke_s, sel_n;
    logic ref_cmd, sre_cmd, srx_cmd, wr_fire, rd_fire, ctrl_wr;
    logic [5:0] ctrl_ff;
    logic [2:0] mode, new_mode;
    logic otf, any_sub;
    srr_pkg::srr_state_t state_ff;
    srr_pkg::srr_rate_t rate_ff, cmd_rate, new_rate;
    logic [1:0] subcnt_ff;
    logic owed_ff;
    logic [CNT_W-1:0] ext_busy_ff, int_busy_ff, timer_ff, exit_cnt_ff;
    logic [CNT_W-1:0] xs_tgt_ff;
    logic [15:0] refcnt_ff;
    logic dll_reset_ff, wref_keep_ff;

    assign cke_s = pin_s_ff[0];
    assign sel_n = pin_s_ff[1];
    assign mode = ctrl_ff[srr_pkg::CTRL_MODE_LSB +: 3];
    assign new_mode = wdata[srr_pkg::CTRL_MODE_LSB +: 3];
    assign otf = mode[2];

    // ========================================================
    // Command decode: self refresh ignores all but CKE and CS_n
    assign ref_cmd = (state_ff != srr_pkg::ST_SELF) && cke_s && !sel_n &&
        pin_s_ff[2] && !pin_s_ff[3] && !pin_s_ff[4] && pin_s_ff[5];
    assign sre_cmd = (state_ff != srr_pkg::ST_SELF) && !cke_s && !sel_n &&
        pin_s_ff[2] && !pin_s_ff[3] && !pin_s_ff[4] && pin_s_ff[5];
    assign srx_cmd = (state_ff == srr_pkg::ST_SELF) && cke_s && sel_n;
    // OTF refresh picks its rate from bank group 0
    assign cmd_rate = (otf && !pin_s_ff[6]) ? srr_pkg::RATE_1X : sub_of(mode);
    // Same rate across fixed/OTF switch is kept
    assign new_rate = (sub_of(new_mode) == rate_ff) ? rate_ff :
        (new_mode[2] ? srr_pkg::RATE_1X : sub_of(new_mode));
    assign any_sub = (rate_ff != srr_pkg::RATE_1X) || (sub_of(mode) !=
        srr_pkg::RATE_1X);

    // ========================================================
    // AXI4-Lite slave, address and data taken together
    assign wr_fire = awvalid && wvalid && !bvalid;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign arready = arvalid && !rvalid;
    assign rd_fire = arready;
    assign ctrl_wr = wr_fire && wstrb[0] && (awaddr == srr_pkg::ADDR_CTRL);

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= srr_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= (awaddr == srr_pkg::ADDR_CTRL) ? srr_pkg::RESP_OKAY :
                srr_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= srr_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rresp <= srr_pkg::RESP_OKAY;
            case (araddr)
                srr_pkg::ADDR_CTRL: rdata <= {26'h0, ctrl_ff};
                srr_pkg::ADDR_STATUS: rdata <= {16'h0, (ext_busy_ff != '0),
                    dll_enable, odt_enable,
                    ctrl_ff[srr_pkg::CTRL_TCR_BIT] && (mode != 3'h0),
                    rate_ff, subcnt_ff, owed_ff, (int_busy_ff != '0),
                    write_ready, ready_dll, ready_fast, ready_no_dll,
                    (state_ff == srr_pkg::ST_EXIT), in_self_refresh};
                srr_pkg::ADDR_REFCNT: rdata <= {16'h0, refcnt_ff};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= srr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= srr_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_ff <= wdata[5:0];
        end
    end

    // ========================================================
    // Current rate: a mode write or an OTF refresh changes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_ff <= srr_pkg::RATE_1X;
        end else if (ctrl_wr) begin
            rate_ff <= new_rate;
        end else if (ref_cmd) begin
            rate_ff <= cmd_rate;
        end
    end

    // Modulo-four sub-rate count and extra-refresh debt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            subcnt_ff <= 2'h0;
            owed_ff <= 1'b0;
        end else if (sre_cmd) begin
            owed_ff <= any_sub && (subcnt_ff != 2'h0);
        end else if (srx_cmd || (ctrl_wr && new_rate != rate_ff)) begin
            subcnt_ff <= 2'h0;
        end else if (ref_cmd) begin
            if (cmd_rate == srr_pkg::RATE_1X) begin
                subcnt_ff <= 2'h0;
                owed_ff <= 1'b0;
            end else begin
                subcnt_ff <= subcnt_ff + 2'h1;
                // Two REF2x or four REF4x settle the debt
                if ((cmd_rate == srr_pkg::RATE_2X && subcnt_ff[0]) ||
                    subcnt_ff == 2'h3) begin
                    owed_ff <= 1'b0;
                end
            end
        end
    end

    // External refresh busy time from the command's own rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_busy_ff <= '0;
        end else if (ref_cmd) begin
            ext_busy_ff <= trfc_of(cmd_rate);
        end else if (ext_busy_ff != '0) begin
            ext_busy_ff <= ext_busy_ff - CNT_W'(1);
        end
    end

    // ========================================================
    // Self-refresh state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= srr_pkg::ST_NORMAL;
        end else begin
            case (state_ff)
                srr_pkg::ST_NORMAL: if (sre_cmd) begin
                    state_ff <= srr_pkg::ST_SELF;
                end
                srr_pkg::ST_SELF: if (srx_cmd) begin
                    state_ff <= srr_pkg::ST_EXIT;
                end
                srr_pkg::ST_EXIT: begin
                    if (sre_cmd) begin
                        state_ff <= srr_pkg::ST_SELF;
                    end else if (ready_dll) begin
                        state_ff <= srr_pkg::ST_NORMAL;
                    end
                end
                default: state_ff <= srr_pkg::ST_NORMAL;
            endcase
        end
    end

    // Internal refresh timer and refresh counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_busy_ff <= '0;
            timer_ff <= '0;
            refcnt_ff <= 16'h0000;
        end else if (sre_cmd) begin
            int_busy_ff <= trfc_of(srr_pkg::RATE_1X);
            timer_ff <= CNT_W'(srr_pkg::TREFI_CYC);
        end else if (srx_cmd && ctrl_ff[srr_pkg::CTRL_ABORT_BIT]) begin
            int_busy_ff <= '0;
        end else if (state_ff == srr_pkg::ST_SELF && timer_ff == '0) begin
            int_busy_ff <= trfc_of(srr_pkg::RATE_1X);
            timer_ff <= CNT_W'(srr_pkg::TREFI_CYC);
        end else begin
            if (timer_ff != '0) begin
                timer_ff <= timer_ff - CNT_W'(1);
            end
            if (int_busy_ff == CNT_W'(1)) begin
                refcnt_ff <= refcnt_ff + 16'h0001;
            end
            if (int_busy_ff != '0) begin
                int_busy_ff <= int_busy_ff - CNT_W'(1);
            end
        end
    end

    // Exit delay counter; target fixed at the exit edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exit_cnt_ff <= '0;
            xs_tgt_ff <= '0;
        end else if (srx_cmd) begin
            exit_cnt_ff <= '0;
            xs_tgt_ff <= ctrl_ff[srr_pkg::CTRL_ABORT_BIT] ?
                CNT_W'(srr_pkg::ABORT_EXIT_CYC) : xs_of(rate_ff);
        end else if (state_ff == srr_pkg::ST_EXIT &&
            exit_cnt_ff != CNT_W'(srr_pkg::DLL_LOCK_EXIT_CYC)) begin
            exit_cnt_ff <= exit_cnt_ff + CNT_W'(1);
        end
    end

    // DLL reset pulse and write reference keep bit latched at entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dll_reset_ff <= 1'b0;
            wref_keep_ff <= 1'b1;
        end else begin
            dll_reset_ff <= srx_cmd;
            if (sre_cmd) begin
                wref_keep_ff <= ctrl_ff[srr_pkg::CTRL_WREF_BIT];
            end
        end
    end

    // ========================================================
    // Outputs
    assign in_self_refresh = (state_ff == srr_pkg::ST_SELF);
    assign odt_enable = !in_self_refresh;
    assign dll_enable = !in_self_refresh;
    assign dll_reset = dll_reset_ff;
    assign write_ref_on = !in_self_refresh || wref_keep_ff;
    assign ready_no_dll = (state_ff == srr_pkg::ST_NORMAL) ||
        (state_ff == srr_pkg::ST_EXIT && exit_cnt_ff >= xs_tgt_ff);
    assign ready_fast = (state_ff == srr_pkg::ST_NORMAL) ||
        (state_ff == srr_pkg::ST_EXIT &&
        exit_cnt_ff >= CNT_W'(srr_pkg::FAST_EXIT_CYC));
    assign ready_dll = (state_ff == srr_pkg::ST_NORMAL) ||
        (state_ff == srr_pkg::ST_EXIT &&
        exit_cnt_ff == CNT_W'(srr_pkg::DLL_LOCK_EXIT_CYC));
    assign write_ready = wref_keep_ff ? ready_no_dll : ready_dll;
endmodule

// file: tb/srr_ctrl_model.sv
// Behavioural memory controller driving the command pins
`timescale 1ns/1ns
module srr_ctrl_model (
    input wire logic aclk, // Clock
    input wire logic [2:0] op, // Command asked by bench
    output logic cke = 1'b1, // Clock enable
    output logic cs_n = 1'b1, // Select
    output logic act_n = 1'b1, // Activate
    output logic ras_n = 1'b1, // Row strobe
    output logic cas_n = 1'b1, // Column strobe
    output logic we_n = 1'b1, // Write enable
    output logic bg0 = 1'b0 // Sub-rate select
);
    // Pins change just after each edge
    always @(posedge aclk) begin
        case (op)
            3'h1, 3'h2: begin // Refresh from idle, bg0 picks sub-rate
                {cke, cs_n, act_n, ras_n, cas_n, we_n} <= 6'b101001;
                bg0 <= op[1];
            end
            3'h3: begin // Entry from idle
                {cke, cs_n, act_n, ras_n, cas_n, we_n} <= 6'b001001;
            end
            3'h4: begin // Hold cke low, scramble the ignored pins
                cke <= 1'b0;
                {cs_n, act_n, ras_n, cas_n, we_n, bg0} <=
                    ~{cs_n, act_n, ras_n, cas_n, we_n, bg0};
            end
            default: begin // Deselect with cke high, also the exit
                {cke, cs_n} <= 2'b11;
                {act_n, ras_n, cas_n, we_n} <= ~{act_n, ras_n, cas_n, we_n};
            end
        endcase
    end
endmodule

// file: tb/srr_refresh_checker.sv
// Port assertions for the refresh and self-refresh block
`timescale 1ns/1ns
module srr_refresh_checker (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Select
    input wire logic act_n, // Activate
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [1:0] bresp, // Write resp
    input wire logic bvalid, // Resp valid
    input wire logic bready, // Resp ready
    input wire logic in_self_refresh, // In SR
    input wire logic odt_enable, // Termination
    input wire logic dll_enable, // DLL on
    input wire logic dll_reset, // DLL reset
    input wire logic ready_no_dll, // Exit ready
    input wire logic ready_fast, // Fast ready
    input wire logic ready_dll, // DLL ready
    input wire logic write_ready // Write ok
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ========================================================
    // Entry and exit steps, write response hold
    sequence s_entry_pins;
        !cke && !cs_n && act_n && !ras_n && !cas_n && we_n;
    endsequence
    sequence s_exit_quiet;
        (!ready_no_dll && !ready_dll) [*8];
    endsequence
    a_entry_decode: assert property (
        $past(cke) && !in_self_refresh ##0 s_entry_pins
        |-> ##[2:4] in_self_refresh) else $error("entry not taken");
    a_sr_ignores: assert property (
        in_self_refresh && !cke && !$past(cke) && !$past(cke, 2)
        |=> in_self_refresh) else $error("left self refresh");
    a_sr_odt_off: assert property (
        in_self_refresh |-> !odt_enable && !dll_enable)
        else $error("odt or dll on in self refresh");
    a_odt_back_on: assert property (
        !in_self_refresh |-> odt_enable && dll_enable)
        else $error("odt or dll off outside self refresh");
    a_dll_reset_exit: assert property (
        $fell(in_self_refresh) |-> ##[0:1] dll_reset)
        else $error("no dll reset on exit");
    a_dll_reset_pulse: assert property (
        dll_reset |=> !dll_reset) else $error("dll reset too long");
    a_exit_wait: assert property (
        $fell(in_self_refresh) |-> s_exit_quiet)
        else $error("ready too early after exit");
    a_ready_order: assert property (
        ready_dll |-> ready_no_dll) else $error("dll ready first");
    a_fast_order: assert property (
        ready_no_dll |-> ready_fast) else $error("fast ready late");
    a_write_gate: assert property (
        write_ready |-> ready_no_dll) else $error("write ready early");
    a_bresp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
endmodule
bind srr_refresh_ctrl srr_refresh_checker chk (.aclk, .aresetn, .cke,
    .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bresp, .bvalid, .bready,
    .in_self_refresh, .odt_enable, .dll_enable, .dll_reset,
    .ready_no_dll, .ready_fast, .ready_dll, .write_ready);

// file: tb/srr_refresh_ctrl_tb_top.sv
// Self-checking bench for the refresh and self-refresh block
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    fail_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module srr_refresh_ctrl_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
    logic arready, rvalid, cke, cs_n, act_n, ras_n, cas_n, we_n, bg0;
    logic [1:0] bresp, rresp;
    logic in_self_refresh, odt_enable, dll_enable, dll_reset;
    logic write_ref_on, ready_no_dll, ready_fast, ready_dll, write_ready;
    logic [2:0] op = 3'h0;
    int fail_count = 0, tests_run = 0, nrst = 0;
    srr_refresh_ctrl uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cke, .cs_n,
        .act_n, .ras_n, .cas_n, .we_n, .bg0, .in_self_refresh, .odt_enable,
        .dll_enable, .dll_reset, .write_ref_on, .ready_no_dll, .ready_fast,
        .ready_dll, .write_ready);
    srr_ctrl_model ctl (.aclk, .op, .cke, .cs_n, .act_n, .ras_n, .cas_n,
        .we_n, .bg0);
    // Clock and dll reset pulse count
    initial begin
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (dll_reset === 1'b1) nrst++;
    // ========================================================
    // Tasks
    task automatic end_sim;
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo(input int k);
        if (k >= 2000) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && k < 2000);
        bready <= 1'b0;
        tmo(k);
        `CHK("bresp", er, bresp)
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [1:0] er);
        int k;
        k = 0;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && k < 2000);
        rready <= 1'b0;
        rd_d = rdata;
        tmo(k);
        `CHK("rresp", er, rresp)
        @(posedge aclk);
    endtask
    task automatic sr_enter(input int n);
        op <= 3'h3;
        cyc(1);
        op <= 3'h4;
        cyc(n);
    endtask
    task automatic exit_run(input int tgt, input logic wexp);
        int k;
        int n;
        k = 0;
        n = 0;
        op <= 3'h5;
        while (in_self_refresh !== 1'b0 && k < 2000) begin
            @(posedge aclk);
            k++;
        end
        tmo(k);
        while (ready_no_dll !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        `CHK("exit_gap", 1'b1, n >= tgt - 1 && n <= tgt + 2)
        `CHK("write_ready", wexp, write_ready)
        while (ready_dll !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        tmo(n);
        `CHK("dll_gap", 1'b1, n >= srr_pkg::DLL_LOCK_EXIT_CYC - 2
            && n <= srr_pkg::DLL_LOCK_EXIT_CYC + 2)
    endtask
    task automatic ref2(input int n, input logic [2:0] o);
        repeat (n) begin
            op <= o;
            cyc(1);
            op <= 3'h0;
            cyc(srr_pkg::TRFC1_CYC + 2);
        end
    endtask
    // ========================================================
    // Main sequence
    initial begin
        cyc(4);
        aresetn <= 1'b1;
        cyc(1);
        `CHK("odt", 1'b1, odt_enable)
        `CHK("in_sr", 1'b0, in_self_refresh)
        `CHK("ready_dll", 1'b1, ready_dll)
        rd(srr_pkg::ADDR_CTRL, srr_pkg::RESP_OKAY);
        `CHK("ctrl", {26'h0, srr_pkg::CTRL_RESET}, rd_d)
        wr(srr_pkg::ADDR_STATUS, 32'h0, srr_pkg::RESP_SLVERR);
        rd(4'hC, srr_pkg::RESP_SLVERR);
        wr(srr_pkg::ADDR_CTRL, 32'h1, srr_pkg::RESP_OKAY);
        ref2(3, 3'h1);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("rate", srr_pkg::RATE_2X, rd_d[11:10])
        `CHK("subcount", 2'h3, rd_d[9:8])
        sr_enter(80);
        `CHK("in_sr", 1'b1, in_self_refresh)
        `CHK("dll", 1'b0, dll_enable)
        `CHK("wref", 1'b0, write_ref_on)
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("owed", 1'b1, rd_d[7])
        rd(srr_pkg::ADDR_REFCNT, srr_pkg::RESP_OKAY);
        `CHK("refcnt", 32'h1, rd_d)
        exit_run(srr_pkg::XS2_CYC, 1'b0);
        ref2(2, 3'h1);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("owed", 1'b0, rd_d[7])
        wr(srr_pkg::ADDR_CTRL, 32'h30, srr_pkg::RESP_OKAY);
        sr_enter(20);
        `CHK("wref", 1'b1, write_ref_on)
        exit_run(srr_pkg::ABORT_EXIT_CYC, 1'b1);
        rd(srr_pkg::ADDR_REFCNT, srr_pkg::RESP_OKAY);
        `CHK("refcnt", 32'h1, rd_d)
        // Fixed 4x entry with one REF4x done owes four more
        wr(srr_pkg::ADDR_CTRL, 32'h2, srr_pkg::RESP_OKAY);
        ref2(1, 3'h1);
        sr_enter(10);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("owed", 1'b1, rd_d[7])
        `CHK("rate", srr_pkg::RATE_4X, rd_d[11:10])
        exit_run(srr_pkg::XS4_CYC, 1'b0);
        ref2(3, 3'h1);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("owed", 1'b1, rd_d[7])
        ref2(1, 3'h1);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("owed", 1'b0, rd_d[7])
        wr(srr_pkg::ADDR_CTRL, 32'h9, srr_pkg::RESP_OKAY);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("conflict", 1'b1, rd_d[12])
        // Fixed 2x to OTF 1x/2x keeps the rate and the count
        ref2(1, 3'h1);
        wr(srr_pkg::ADDR_CTRL, 32'h5, srr_pkg::RESP_OKAY);
        ref2(1, 3'h2);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("rate", srr_pkg::RATE_2X, rd_d[11:10])
        `CHK("subcount", 2'h2, rd_d[9:8])
        ref2(1, 3'h1);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("rate", srr_pkg::RATE_1X, rd_d[11:10])
        `CHK("subcount", 2'h0, rd_d[9:8])
        wr(srr_pkg::ADDR_CTRL, 32'h8, srr_pkg::RESP_OKAY);
        rd(srr_pkg::ADDR_STATUS, srr_pkg::RESP_OKAY);
        `CHK("conflict", 1'b0, rd_d[12])
        `CHK("dll_resets", 3, nrst)
        end_sim();
    end
endmodule
